//--- rtl/prg_pins.sv
// request/grant pin muxing, internal arbiter, bus reset and system error for the bus interface
//
// Contract
// - system error line pulled low on address/special-cycle parity or other system error
// - all bus activity timed from the bus clock input
// - host mode drives bus reset active to reset the bus
// - satellite mode starts a warm reset when bus reset is asserted externally
// - target claim asserted low after own address space decode
// - internal arbiter asserts matching low grant to the chosen agent
// - host with external arbiter: request 0 asks for bus, requests 3..1 high
// - host with external arbiter: grant 0 is input, grants 3..1 held high
// - satellite: request 0 asks for bus, requests 3..2 held high
// - satellite: grant 0 is input from arbiter, grants 3..2 held high
// - satellite: grant pin 1 becomes serial EEPROM chip select output
// - gpio 24 and 27 alternate function become requests 4 and 5
// - gpio 26 and 28 alternate function become grants 4 and 5
// - without alternate function these pins are plain gpio
`default_nettype none
module prg_pins
	import prg_pkg::*;
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic [2:0] mode,
	input wire logic host_reset_req,
	input wire logic own_bus_req,
	output logic own_bus_granted,
	input wire logic [3:0] bus_request_n_in,
	output logic [3:0] bus_request_n_out,
	output logic [3:0] bus_request_n_oe_n,
	input wire logic [3:0] bus_grant_n_in,
	output logic [3:0] bus_grant_n_out,
	output logic [3:0] bus_grant_n_oe_n,
	input wire logic bus_reset_n_in,
	output logic bus_reset_n_out,
	output logic bus_reset_n_oe_n,
	output logic warm_reset,
	input wire logic system_error_n_in,
	output logic system_error_n_out,
	output logic system_error_n_oe_n,
	input wire logic addr_parity_err,
	input wire logic special_parity_err,
	input wire logic other_sys_err,
	output logic system_error_seen,
	input wire logic addr_decode_hit,
	input wire logic [1:0] target_claim_n_in,
	output logic target_claim_n_out,
	output logic target_claim_n_oe_n,
	output logic config_device_select,
	input wire logic eeprom_select,
	input wire logic [PRG_NGPIO-1:0] gpio_alt_sel,
	input wire logic [PRG_NGPIO-1:0] gpio_out,
	input wire logic [PRG_NGPIO-1:0] gpio_dir_out,
	output logic [PRG_NGPIO-1:0] gpio_in,
	input wire logic [PRG_NGPIO-1:0] gpio_pin_in,
	output logic [PRG_NGPIO-1:0] gpio_pin_out,
	output logic [PRG_NGPIO-1:0] gpio_pin_oe_n,
	output logic [PRG_NREQ-1:0] grant_vec
);
	timeunit 1ns;
	timeprecision 1ps;
	prg_mode_t mode_q;
	prg_arb_t arb_q;
	logic [3:0] req_s1_q, req_s2_q, gnt_s1_q, gnt_s2_q;
	logic rst_s1_q, rst_s2_q, serr_s1_q, serr_s2_q;
	logic [1:0] claim_s1_q, claim_s2_q;
	logic [PRG_NGPIO-1:0] gp_s1_q, gp_s2_q;
	logic [PRG_NREQ-1:0] req_act;
	logic [PRG_NREQ-1:0] grant_q, grant_d;
	logic [2:0] last_q;
	logic alt_req4, alt_req5, alt_gnt4, alt_gnt5;

	// lowest-index requester after the previous winner, rotating priority
	function automatic logic [PRG_NREQ-1:0] prg_pick(input logic [PRG_NREQ-1:0] req, input logic [2:0] last);
		logic [PRG_NREQ-1:0] res;
		int idx;
		res = PRG_GRANT_NONE;
		for (int k = PRG_NREQ; k >= 1; k--) begin
			idx = (int'(last) + k) % PRG_NREQ;
			if (req[idx])
				res = PRG_GRANT_NONE | (6'h01 << idx);
		end
		return res;
	endfunction : prg_pick

	function automatic logic [2:0] prg_index(input logic [PRG_NREQ-1:0] onehot);
		logic [2:0] r;
		r = 3'h0;
		for (int k = 0; k < PRG_NREQ; k++) begin
			if (onehot[k])
				r = 3'(k);
		end
		return r;
	endfunction : prg_index

	assign alt_req4 = gpio_alt_sel[PRG_GPIO_REQ4];
	assign alt_req5 = gpio_alt_sel[PRG_GPIO_REQ5];
	assign alt_gnt4 = gpio_alt_sel[PRG_GPIO_GNT4];
	assign alt_gnt5 = gpio_alt_sel[PRG_GPIO_GNT5];

	// mode latched each cycle; unknown codes fall back to host with internal arbiter
	always_ff @(posedge mclk) begin
		if (reset)
			mode_q <= PRG_MODE_HOST_INT;
		else begin
			case (mode)
				PRG_MODE_HOST_EXT: mode_q <= PRG_MODE_HOST_EXT;
				PRG_MODE_SAT: mode_q <= PRG_MODE_SAT;
				default: mode_q <= PRG_MODE_HOST_INT;
			endcase
		end
	end

	// every pin input synchronised before use, all on the bus clock
	always_ff @(posedge mclk) begin
		if (reset) begin
			// released pins idle high
			{req_s1_q, req_s2_q, gnt_s1_q, gnt_s2_q, rst_s1_q, rst_s2_q} <= '1;
			{serr_s1_q, serr_s2_q, claim_s1_q, claim_s2_q, gp_s1_q, gp_s2_q} <= '1;
		end else begin
			{req_s2_q, req_s1_q} <= {req_s1_q, bus_request_n_in};
			{gnt_s2_q, gnt_s1_q} <= {gnt_s1_q, bus_grant_n_in};
			{rst_s2_q, rst_s1_q} <= {rst_s1_q, bus_reset_n_in};
			{serr_s2_q, serr_s1_q} <= {serr_s1_q, system_error_n_in};
			{claim_s2_q, claim_s1_q} <= {claim_s1_q, target_claim_n_in};
			{gp_s2_q, gp_s1_q} <= {gp_s1_q, gpio_pin_in};
		end
	end

	always_comb begin
		req_act = PRG_REQ_NONE;
		if (mode_q == PRG_MODE_HOST_INT) begin
			req_act[3:0] = ~req_s2_q;
			req_act[4] = alt_req4 & ~gp_s2_q[PRG_GPIO_REQ4];
			req_act[5] = alt_req5 & ~gp_s2_q[PRG_GPIO_REQ5];
		end
	end

	// a grant stays with its owner while it still requests, then rotates
	always_comb begin
		grant_d = PRG_GRANT_NONE;
		case (arb_q)
			PRG_ARB_GRANT: grant_d = ((grant_q & req_act) != PRG_GRANT_NONE) ? grant_q : prg_pick(req_act, last_q);
			PRG_ARB_IDLE: grant_d = prg_pick(req_act, last_q);
			default: grant_d = PRG_GRANT_NONE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			arb_q <= PRG_ARB_IDLE;
			grant_q <= PRG_GRANT_NONE;
			last_q <= 3'h0;
		end else if (mode_q != PRG_MODE_HOST_INT) begin
			arb_q <= PRG_ARB_IDLE;
			grant_q <= PRG_GRANT_NONE;
		end else begin
			// two idle cycles between owners so two grants never overlap on the bus
			case (arb_q)
				PRG_ARB_IDLE: arb_q <= (grant_d != PRG_GRANT_NONE) ? PRG_ARB_GRANT : PRG_ARB_IDLE;
				PRG_ARB_GRANT: arb_q <= (grant_d == grant_q) ? PRG_ARB_GRANT : PRG_ARB_PARK;
				default: arb_q <= PRG_ARB_IDLE;
			endcase
			grant_q <= (arb_q == PRG_ARB_GRANT && grant_d != grant_q) ? PRG_GRANT_NONE : grant_d;
			// only a grant actually loaded moves the priority, so a pending pick is not skipped
			if (arb_q == PRG_ARB_IDLE && grant_d != PRG_GRANT_NONE)
				last_q <= prg_index(grant_d);
		end
	end

	// request and grant pins per mode
	always_ff @(posedge mclk) begin
		if (reset) begin
			bus_request_n_out <= PRG_PIN_IDLE;
			bus_request_n_oe_n <= PRG_PIN_IDLE;
			bus_grant_n_out <= PRG_PIN_IDLE;
			bus_grant_n_oe_n <= PRG_PIN_IDLE;
			config_device_select <= 1'b0;
			own_bus_granted <= 1'b0;
			grant_vec <= PRG_GRANT_NONE;
		end else begin
			grant_vec <= grant_q;
			case (mode_q)
				PRG_MODE_HOST_EXT: begin
					bus_request_n_out <= {3'h7, ~own_bus_req};
					bus_request_n_oe_n <= 4'h0;
					bus_grant_n_out <= PRG_PIN_IDLE;
					bus_grant_n_oe_n <= 4'h1;
					own_bus_granted <= ~gnt_s2_q[0];
					config_device_select <= 1'b0;
				end
				PRG_MODE_SAT: begin
					bus_request_n_out <= {2'h3, 1'b1, ~own_bus_req};
					bus_request_n_oe_n <= 4'h2;
					config_device_select <= req_s2_q[1];
					bus_grant_n_out <= {2'h3, ~eeprom_select, 1'b1};
					bus_grant_n_oe_n <= 4'h1;
					own_bus_granted <= ~gnt_s2_q[0];
				end
				default: begin
					bus_request_n_out <= PRG_PIN_IDLE;
					bus_request_n_oe_n <= PRG_PIN_IDLE;
					bus_grant_n_out <= ~grant_q[3:0];
					bus_grant_n_oe_n <= 4'h0;
					own_bus_granted <= 1'b1;
					config_device_select <= 1'b0;
				end
			endcase
		end
	end

	// shared gpio pins: alternate function or plain gpio
	always_ff @(posedge mclk) begin
		if (reset) begin
			gpio_pin_out <= '1;
			gpio_pin_oe_n <= '1;
			gpio_in <= '0;
		end else begin
			gpio_in <= gp_s2_q;
			gpio_pin_out <= gpio_out;
			gpio_pin_oe_n <= ~gpio_dir_out;
			if (alt_req4)
				gpio_pin_oe_n[PRG_GPIO_REQ4] <= 1'b1;
			if (alt_req5)
				gpio_pin_oe_n[PRG_GPIO_REQ5] <= 1'b1;
			if (alt_gnt4) begin
				gpio_pin_out[PRG_GPIO_GNT4] <= ~grant_q[4];
				gpio_pin_oe_n[PRG_GPIO_GNT4] <= 1'b0;
			end
			if (alt_gnt5) begin
				gpio_pin_out[PRG_GPIO_GNT5] <= ~grant_q[5];
				gpio_pin_oe_n[PRG_GPIO_GNT5] <= 1'b0;
			end
		end
	end

	// bus reset, system error and target claim
	always_ff @(posedge mclk) begin
		if (reset) begin
			bus_reset_n_out <= 1'b0;
			bus_reset_n_oe_n <= 1'b1;
			warm_reset <= 1'b0;
			system_error_n_out <= 1'b0;
			system_error_n_oe_n <= 1'b1;
			system_error_seen <= 1'b0;
			target_claim_n_out <= 1'b1;
			target_claim_n_oe_n <= 1'b1;
		end else begin
			bus_reset_n_out <= 1'b0;
			bus_reset_n_oe_n <= ~((mode_q != PRG_MODE_SAT) & host_reset_req);
			warm_reset <= (mode_q == PRG_MODE_SAT) & ~rst_s2_q;
			system_error_n_out <= 1'b0;
			system_error_n_oe_n <= ~(addr_parity_err | special_parity_err | other_sys_err);
			system_error_seen <= ~serr_s2_q;
			target_claim_n_out <= ~addr_decode_hit;
			target_claim_n_oe_n <= ~addr_decode_hit;
		end
	end

	AST_ONE_GRANT: assert property (@(posedge mclk) disable iff (reset) $onehot0(grant_q))
		else $error("more than one grant active");
	AST_GRANT_REQ: assert property (@(posedge mclk) disable iff (reset)
		(grant_q != PRG_GRANT_NONE) |-> ((grant_q & $past(req_act)) != PRG_GRANT_NONE))
		else $error("grant to an agent not requesting");
	AST_GNT_PIN: assert property (@(posedge mclk) disable iff (reset)
		(mode_q == PRG_MODE_HOST_INT) ##1 (mode_q == PRG_MODE_HOST_INT) |-> bus_grant_n_out == ~$past(grant_q[3:0]))
		else $error("grant pins do not follow arbiter");
	AST_EXT_REQ: assert property (@(posedge mclk) disable iff (reset)
		(mode_q == PRG_MODE_HOST_EXT) |=> bus_request_n_out[3:1] == 3'h7 && bus_request_n_out[0] == ~$past(own_bus_req))
		else $error("external arbiter request pins wrong");
	AST_EXT_GNT: assert property (@(posedge mclk) disable iff (reset)
		(mode_q == PRG_MODE_HOST_EXT) |=> bus_grant_n_out[3:1] == 3'h7 && bus_grant_n_oe_n[0])
		else $error("external arbiter grant pins wrong");
	AST_SAT_REQ: assert property (@(posedge mclk) disable iff (reset)
		(mode_q == PRG_MODE_SAT) |=> bus_request_n_out[3:2] == 2'h3 && bus_request_n_oe_n[1])
		else $error("satellite request pins wrong");
	AST_SAT_EECS: assert property (@(posedge mclk) disable iff (reset)
		(mode_q == PRG_MODE_SAT) |=> bus_grant_n_out[1] == ~$past(eeprom_select) && bus_grant_n_out[3:2] == 2'h3)
		else $error("eeprom select pin wrong");
	AST_WARM: assert property (@(posedge mclk) disable iff (reset)
		(mode_q == PRG_MODE_SAT && !bus_reset_n_in) ##1 (mode_q == PRG_MODE_SAT) [*3] |-> warm_reset)
		else $error("warm reset missed");
	AST_SERR: assert property (@(posedge mclk) disable iff (reset)
		addr_parity_err |=> !system_error_n_oe_n && !system_error_n_out)
		else $error("system error not driven");
	AST_GNT4: assert property (@(posedge mclk) disable iff (reset)
		alt_gnt4 |=> !gpio_pin_oe_n[PRG_GPIO_GNT4] && gpio_pin_out[PRG_GPIO_GNT4] == ~$past(grant_q[4]))
		else $error("grant 4 pin wrong");
	COV_GRANT: cover property (@(posedge mclk) disable iff (reset) grant_q != PRG_GRANT_NONE);
	COV_HANDOFF: cover property (@(posedge mclk) disable iff (reset) arb_q == PRG_ARB_PARK);
	COV_SAT_WARM: cover property (@(posedge mclk) disable iff (reset) warm_reset);
endmodule : prg_pins
`default_nettype wire

//--- shared/prg_pkg.sv
// package with mode codes, pin positions and reset values for the request/grant pin block
`default_nettype none
package prg_pkg;
	timeunit 1ns;
	timeprecision 1ps;
	typedef enum logic [2:0] {
		PRG_MODE_HOST_INT = 3'h1,
		PRG_MODE_HOST_EXT = 3'h2,
		PRG_MODE_SAT = 3'h4
	} prg_mode_t;
	typedef enum logic [2:0] {
		PRG_ARB_IDLE = 3'h1,
		PRG_ARB_GRANT = 3'h2,
		PRG_ARB_PARK = 3'h4
	} prg_arb_t;
	localparam int PRG_NREQ = 6;
	localparam int PRG_NGPIO = 32;
	localparam int PRG_GPIO_REQ4 = 24;
	localparam int PRG_GPIO_REQ5 = 27;
	localparam int PRG_GPIO_GNT4 = 26;
	localparam int PRG_GPIO_GNT5 = 28;
	localparam logic [3:0] PRG_PIN_IDLE = 4'hf;
	localparam logic [5:0] PRG_GRANT_NONE = 6'h00;
	localparam logic [5:0] PRG_REQ_NONE = 6'h00;
endpackage : prg_pkg
`default_nettype wire

//--- bench/prg_far_side.sv
// far-side agents, external arbiter and pull-ups on the request/grant pins
`default_nettype none
module prg_far_side (
	input wire logic [3:0] req_out,
	input wire logic [3:0] req_oe_n,
	input wire logic [3:0] agent_req,
	output logic [3:0] req_in,
	input wire logic [3:0] gnt_out,
	input wire logic [3:0] gnt_oe_n,
	input wire logic ext_gnt,
	output logic [3:0] gnt_in,
	input wire logic rst_out,
	input wire logic rst_oe_n,
	input wire logic rst_ext,
	output logic rst_in,
	input wire logic serr_out,
	input wire logic serr_oe_n,
	input wire logic serr_pull,
	output logic serr_in,
	input wire logic [31:0] pin_out,
	input wire logic [31:0] pin_oe_n,
	input wire logic [31:0] pin_ext,
	output logic [31:0] pin_in
);
	timeunit 1ns;
	timeprecision 1ps;
	// released request pins float high; agents pull low to ask, bit 1 doubles as select
	assign req_in = (~req_oe_n & req_out) | (req_oe_n & ~agent_req);
	assign gnt_in = (~gnt_oe_n & gnt_out) | (gnt_oe_n & {3'h7, ~ext_gnt});
	assign rst_in = rst_oe_n ? ~rst_ext : rst_out;
	// open drain: any party pulling wins
	assign serr_in = !(serr_pull || (!serr_oe_n && !serr_out));
	assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & pin_ext);
endmodule : prg_far_side
`default_nettype wire

//--- bench/prg_pins_tb.sv
// self-checking bench for the request/grant pin block
`default_nettype none
module prg_pins_tb
	import prg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'h0, reset = 1'h1, host_reset_req = 1'h0, own_bus_req = 1'h0, own_bus_granted, warm_reset;
	logic [2:0] mode = 3'h1;
	logic [3:0] bus_request_n_in, bus_request_n_out, bus_request_n_oe_n, bus_grant_n_in, bus_grant_n_out;
	logic [3:0] bus_grant_n_oe_n, agent_req = 4'h0;
	logic bus_reset_n_in, bus_reset_n_out, bus_reset_n_oe_n, system_error_n_in, system_error_n_out;
	logic system_error_n_oe_n, system_error_seen, target_claim_n_out, target_claim_n_oe_n, config_device_select;
	logic addr_parity_err = 1'h0, special_parity_err = 1'h0, other_sys_err = 1'h0, addr_decode_hit = 1'h0;
	logic eeprom_select = 1'h0, ext_gnt = 1'h0, rst_ext = 1'h0, serr_pull = 1'h0;
	logic [31:0] gpio_alt_sel = 32'h0, gpio_out = 32'h0, gpio_dir_out = 32'h0, pin_ext = 32'hffffffff;
	logic [31:0] gpio_in, gpio_pin_in, gpio_pin_out, gpio_pin_oe_n;
	logic [5:0] grant_vec;
	int n_mismatch = 0, tests_run = 0;
	prg_pins i_dut (.mclk, .reset, .mode, .host_reset_req, .own_bus_req, .own_bus_granted, .bus_request_n_in,
		.bus_request_n_out, .bus_request_n_oe_n, .bus_grant_n_in, .bus_grant_n_out, .bus_grant_n_oe_n,
		.bus_reset_n_in, .bus_reset_n_out, .bus_reset_n_oe_n, .warm_reset, .system_error_n_in, .system_error_n_out,
		.system_error_n_oe_n, .addr_parity_err, .special_parity_err, .other_sys_err, .system_error_seen,
		.addr_decode_hit, .target_claim_n_in(2'h3), .target_claim_n_out, .target_claim_n_oe_n, .config_device_select,
		.eeprom_select, .gpio_alt_sel, .gpio_out, .gpio_dir_out, .gpio_in, .gpio_pin_in, .gpio_pin_out,
		.gpio_pin_oe_n, .grant_vec);
	prg_far_side i_far (.req_out(bus_request_n_out), .req_oe_n(bus_request_n_oe_n), .agent_req(agent_req),
		.req_in(bus_request_n_in), .gnt_out(bus_grant_n_out), .gnt_oe_n(bus_grant_n_oe_n), .ext_gnt(ext_gnt),
		.gnt_in(bus_grant_n_in), .rst_out(bus_reset_n_out), .rst_oe_n(bus_reset_n_oe_n), .rst_ext(rst_ext),
		.rst_in(bus_reset_n_in), .serr_out(system_error_n_out), .serr_oe_n(system_error_n_oe_n),
		.serr_pull(serr_pull), .serr_in(system_error_n_in), .pin_out(gpio_pin_out), .pin_oe_n(gpio_pin_oe_n),
		.pin_ext(pin_ext), .pin_in(gpio_pin_in));
	always #2 mclk = ~mclk;
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : cyc
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic t_arb;
		agent_req = 4'h2;
		cyc(6);
		chk("grant pins", {bus_grant_n_oe_n, bus_grant_n_out}, 8'h0d);
		chk("grant vec", grant_vec, 6'h02);
		chk("req released", bus_request_n_oe_n, 4'hf);
		agent_req = 4'h0;
		cyc(6);
		chk("grant drop", {grant_vec, bus_grant_n_out}, 10'h00f);
		agent_req = 4'h5;
		cyc(8);
		chk("one hot", ((grant_vec & (grant_vec - 6'h1)) == 6'h0) && ((grant_vec & 6'h05) != 6'h0), 1);
		chk("grant match", {2'h0, ~bus_grant_n_out}, grant_vec);
		agent_req = 4'h0;
		gpio_alt_sel = 32'h1d000000;
		pin_ext[24] = 1'h0;
		cyc(10);
		chk("alt grant4", {grant_vec, gpio_pin_oe_n[26], gpio_pin_out[26]}, 8'h40);
		pin_ext[24] = 1'h1;
		pin_ext[27] = 1'h0;
		cyc(10);
		chk("alt grant5", {grant_vec, gpio_pin_oe_n[28], gpio_pin_out[28], gpio_pin_out[26]}, 9'h101);
		pin_ext[27] = 1'h1;
		cyc(6);
		$display("done arbiter");
	endtask : t_arb
	task automatic t_gpio;
		gpio_alt_sel = 32'h0;
		gpio_dir_out = 32'h14000000;
		gpio_out = 32'h04000000;
		pin_ext[24] = 1'h0;
		cyc(5);
		chk("plain out", {gpio_pin_oe_n[26], gpio_pin_out[26], gpio_pin_oe_n[28], gpio_pin_out[28]}, 4'h4);
		chk("plain in", {grant_vec, gpio_in[24], gpio_pin_oe_n[24]}, 8'h01);
		pin_ext[24] = 1'h1;
		gpio_dir_out = 32'h0;
		$display("done gpio");
	endtask : t_gpio
	task automatic t_ext;
		mode = 3'h2;
		own_bus_req = 1'h1;
		cyc(3);
		chk("ext req", {bus_request_n_oe_n, bus_request_n_out}, 8'h0e);
		chk("ext gnt", {bus_grant_n_oe_n, bus_grant_n_out[3:1]}, 7'h0f);
		ext_gnt = 1'h1;
		cyc(5);
		chk("granted", {own_bus_granted, grant_vec}, 7'h40);
		ext_gnt = 1'h0;
		own_bus_req = 1'h0;
		cyc(5);
		chk("ext idle", {own_bus_granted, bus_request_n_out[0]}, 2'h1);
		$display("done external arbiter");
	endtask : t_ext
	task automatic t_sat;
		mode = 3'h4;
		own_bus_req = 1'h1;
		eeprom_select = 1'h1;
		agent_req = 4'h2;
		cyc(5);
		chk("sat req", {bus_request_n_oe_n, bus_request_n_out[3:2], bus_request_n_out[0]}, 7'h16);
		chk("sat gnt", {bus_grant_n_oe_n, bus_grant_n_out[3:1]}, 7'h0e);
		chk("idsel off", config_device_select, 1'h0);
		eeprom_select = 1'h0;
		agent_req = 4'h0;
		rst_ext = 1'h1;
		cyc(5);
		chk("eeprom off", bus_grant_n_out[1], 1'h1);
		chk("idsel on", config_device_select, 1'h1);
		chk("warm", {warm_reset, bus_reset_n_oe_n}, 2'h3);
		rst_ext = 1'h0;
		own_bus_req = 1'h0;
		cyc(5);
		chk("warm end", warm_reset, 1'h0);
		$display("done satellite");
	endtask : t_sat
	task automatic t_misc;
		mode = 3'h1;
		host_reset_req = 1'h1;
		cyc(2);
		chk("bus reset", {bus_reset_n_oe_n, bus_reset_n_out}, 2'h0);
		host_reset_req = 1'h0;
		addr_decode_hit = 1'h1;
		cyc(1);
		chk("claim", {target_claim_n_oe_n, target_claim_n_out}, 2'h0);
		addr_decode_hit = 1'h0;
		cyc(2);
		chk("claim off", {target_claim_n_oe_n, bus_reset_n_oe_n}, 2'h3);
		for (int i = 0; i < 3; i++) begin
			{addr_parity_err, special_parity_err, other_sys_err} = 3'h1 << i;
			cyc(2);
			chk("serr drive", {system_error_n_oe_n, system_error_n_out}, 2'h0);
			cyc(3);
			chk("serr seen", system_error_seen, 1'h1);
			{addr_parity_err, special_parity_err, other_sys_err} = 3'h0;
			cyc(5);
			chk("serr idle", {system_error_n_oe_n, system_error_seen}, 2'h2);
		end
		serr_pull = 1'h1;
		cyc(5);
		chk("serr other", {system_error_n_oe_n, system_error_seen}, 2'h3);
		serr_pull = 1'h0;
		$display("done reset, claim and error");
	endtask : t_misc
	task automatic t_reset;
		mode = 3'h4;
		ext_gnt = 1'h1;
		eeprom_select = 1'h1;
		own_bus_req = 1'h1;
		cyc(6);
		chk("sat own", {own_bus_granted, bus_grant_n_out[1], bus_request_n_out[0]}, 3'h4);
		reset = 1'h1;
		cyc(1);
		chk("reset oe", {bus_request_n_oe_n, bus_grant_n_oe_n}, 8'hff);
		chk("reset out", {bus_request_n_out, bus_grant_n_out}, 8'hff);
		chk("reset drive", {bus_reset_n_oe_n, system_error_n_oe_n, target_claim_n_oe_n}, 3'h7);
		chk("reset state", {warm_reset, config_device_select, own_bus_granted, grant_vec}, 9'h000);
		chk("reset gpio", gpio_pin_oe_n, 32'hffffffff);
		mode = 3'h6;
		ext_gnt = 1'h0;
		eeprom_select = 1'h0;
		own_bus_req = 1'h0;
		cyc(3);
		reset = 1'h0;
		cyc(2);
		chk("odd mode", {bus_grant_n_oe_n, bus_request_n_oe_n, bus_grant_n_out}, 12'h0ff);
		agent_req = 4'h1;
		cyc(5);
		chk("odd grant", {grant_vec, bus_grant_n_out}, 10'h01e);
		agent_req = 4'h0;
		$display("done reset and undecoded mode");
	endtask : t_reset
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		#4000;
		n_mismatch++;
		tally_and_finish();
	end
	initial begin
		cyc(4);
		reset = 1'h0;
		cyc(2);
		t_arb();
		t_gpio();
		t_ext();
		t_sat();
		t_misc();
		t_reset();
		tally_and_finish();
	end
endmodule : prg_pins_tb
`default_nettype wire
